// ---- hw/chan_div_regs.vh ----
// Register map, field positions, reset values and state codes for the
// two-stage channel clock divider. Definitions only; included by bare name.
`ifndef CHAN_DIV_REGS_VH
`define CHAN_DIV_REGS_VH

// Register indices; the APB byte address is four times the index
`define IDX_STAGE1_CYCLE_COUNTS 12'h19e
`define IDX_STAGE_PHASE_OFFSETS 12'h19f
`define IDX_STAGE2_CYCLE_COUNTS 12'h1a0
`define IDX_CHANNEL_DIV_CONTROL 12'h1a1
`define IDX_DUTY_CORR_CONTROL 12'h1a2
`define IDX_CHANNEL_STATUS 12'h1a3

// APB address width and word alignment
`define APB_ADDR_W 12
`define APB_WORD_LSB 2

// Cycle count fields (both count registers)
`define FLD_LOW_HI 7
`define FLD_LOW_LO 4
`define FLD_HIGH_HI 3
`define FLD_HIGH_LO 0

// Phase offset fields
`define FLD_PHASE2_HI 7
`define FLD_PHASE2_LO 4
`define FLD_PHASE1_HI 3
`define FLD_PHASE1_LO 0

// Channel control bits
`define BIT_BYPASS2 5
`define BIT_BYPASS1 4
`define BIT_IGNORE_ALIGN 3
`define BIT_FORCE_HIGH 2
`define BIT_START_HIGH2 1
`define BIT_START_HIGH1 0

// Duty correction control bit
`define BIT_DUTY_CORR_DISABLE 0

// Reset values
`define RST_BYTE 8'h00

// Stage states
`define ST_HOLD 2'h0
`define ST_DELAY 2'h1
`define ST_RUN 2'h2

// Duty-correction period counter width
`define PERIOD_W 12

`endif

// ---- hw/div_stage.v ----
// One divider stage: high/low cycle counting, phase offset, start level,
// bypass and alignment hold. Counts only on input ticks from the previous
// stage; all logic runs on the single system clock.
`default_nettype none

module div_stage (
  input wire mclk,
  input wire rst,
  input wire inTick,
  input wire inLevel,
  input wire bypass,
  input wire alignHold,
  input wire startHigh,
  input wire [3:0] lowCount,
  input wire [3:0] highCount,
  input wire [3:0] phase,
  output reg outTick,
  output reg outLevel
);

`include "chan_div_regs.vh"

  reg [1:0] state;
  reg [3:0] cnt;

  ////////////////////////////////////////////////////////////////////////
  // Stage sequencer
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= `ST_HOLD;
      cnt <= 4'h0;
      outLevel <= 1'b0;
      outTick <= 1'b0;
    end else if (bypass) begin
      // Counter held still, input clock routed straight through
      state <= `ST_HOLD;
      cnt <= 4'h0;
      outLevel <= inLevel;
      outTick <= inTick;
    end else if (alignHold) begin
      // Parked at the chosen start level while alignment is asserted
      state <= `ST_HOLD;
      cnt <= 4'h0;
      outLevel <= startHigh;
      outTick <= 1'b0;
    end else begin
      outTick <= 1'b0;
      case (state)
        `ST_HOLD: begin
          // Coarse phase: wait 'phase' input cycles before counting
          cnt <= 4'h0;
          state <= (phase == 4'h0) ? `ST_RUN : `ST_DELAY;
        end
        `ST_DELAY: begin
          if (inTick) begin
            if (cnt == phase - 4'h1) begin
              cnt <= 4'h0;
              state <= `ST_RUN;
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
        end
        `ST_RUN: begin
          if (inTick) begin
            if (outLevel) begin
              // High for highCount+1 input cycles
              if (cnt == highCount) begin
                cnt <= 4'h0;
                outLevel <= 1'b0;
              end else begin
                cnt <= cnt + 4'h1;
              end
            end else begin
              // Low for lowCount+1 input cycles
              if (cnt == lowCount) begin
                cnt <= 4'h0;
                outLevel <= 1'b1;
                outTick <= 1'b1;
              end else begin
                cnt <= cnt + 4'h1;
              end
            end
          end
        end
        default: begin
          state <= `ST_HOLD;
          cnt <= 4'h0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- hw/channel_clock_divider_pair.v ----
// Two-stage channel clock divider with APB register access.
// Assumes one system clock mclk (40 MHz); the channel input clock is
// modelled as mclk/2, and the alignment input is synchronous to mclk.
//
// Register access over APB was chosen for this implementation.
`default_nettype none

module channel_clock_divider_pair (
  input wire mclk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire alignIn,
  output reg chanOut
);

`include "chan_div_regs.vh"

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  // Returns a one-hot select of the mapped registers, zero if unmapped
  function [5:0] decodeReg;
    input [11:0] addr;
    reg [9:0] idx;
    begin
      idx = addr[11:`APB_WORD_LSB];
      decodeReg = 6'h00;
      if (addr[1:0] == 2'h0) begin
        case ({2'h0, idx})
          `IDX_STAGE1_CYCLE_COUNTS: decodeReg = 6'h01;
          `IDX_STAGE_PHASE_OFFSETS: decodeReg = 6'h02;
          `IDX_STAGE2_CYCLE_COUNTS: decodeReg = 6'h04;
          `IDX_CHANNEL_DIV_CONTROL: decodeReg = 6'h08;
          `IDX_DUTY_CORR_CONTROL: decodeReg = 6'h10;
          `IDX_CHANNEL_STATUS: decodeReg = 6'h20;
          default: decodeReg = 6'h00;
        endcase
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register storage

  reg [7:0] stage1Counts;
  reg [7:0] stagePhaseOffsets;
  reg [7:0] stage2Counts;
  reg [7:0] channelDivControl;
  reg [7:0] dutyCorrControl;

  wire [5:0] sel;
  wire accessDone;
  wire writeDone;

  assign sel = decodeReg(paddr);
  // Writes take effect only at the edge that completes the access phase
  assign accessDone = psel & penable & pready;
  assign writeDone = accessDone & pwrite;

  // Software-written configuration
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1Counts <= `RST_BYTE;
      stagePhaseOffsets <= `RST_BYTE;
      stage2Counts <= `RST_BYTE;
      channelDivControl <= `RST_BYTE;
      dutyCorrControl <= `RST_BYTE;
    end else if (writeDone) begin
      if (sel[0]) begin
        stage1Counts <= pwdata[7:0];
      end
      if (sel[1]) begin
        stagePhaseOffsets <= pwdata[7:0];
      end
      if (sel[2]) begin
        stage2Counts <= pwdata[7:0];
      end
      if (sel[3]) begin
        channelDivControl <= {2'h0, pwdata[5:0]};
      end
      if (sel[4]) begin
        dutyCorrControl <= {7'h00, pwdata[`BIT_DUTY_CORR_DISABLE]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB answer path

  wire [7:0] statusByte;
  reg [7:0] readByte;

  // Read multiplexer; unused upper bits read as zero
  always @* begin
    case (sel)
      6'h01: readByte = stage1Counts;
      6'h02: readByte = stagePhaseOffsets;
      6'h04: readByte = stage2Counts;
      6'h08: readByte = channelDivControl;
      6'h10: readByte = dutyCorrControl;
      6'h20: readByte = statusByte;
      default: readByte = 8'h00;
    endcase
  end

  // One wait-free access phase: pready rises in the cycle after setup.
  // Registering pready keeps every output straight off a flip-flop.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= (sel == 6'h00) || (pwrite && sel[5]);
      prdata <= pwrite ? 32'h00000000 : {24'h000000, readByte};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel input clock

  // The channel input clock is a toggle of mclk; a tick marks its rising edge.
  // Limitation: the divider cannot run faster than mclk/2.
  reg refLevel;
  reg refTick;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      refLevel <= 1'b0;
      refTick <= 1'b0;
    end else begin
      refLevel <= ~refLevel;
      refTick <= ~refLevel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alignment handling

  wire ignoreAlign;
  wire alignHold;

  // Each stage not in bypass obeys the alignment input unless told to ignore it
  assign ignoreAlign = channelDivControl[`BIT_IGNORE_ALIGN];
  assign alignHold = alignIn & ~ignoreAlign;

  ////////////////////////////////////////////////////////////////////////
  // Divider chain

  // Index 0 is the channel input clock; index i+1 is stage i's output
  wire [2:0] chainTick;
  wire [2:0] chainLevel;

  assign chainTick[0] = refTick;
  assign chainLevel[0] = refLevel;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : gStage
      wire stBypass;
      wire stStart;
      wire [3:0] stLow;
      wire [3:0] stHigh;
      wire [3:0] stPhase;

      // Per-stage field selection
      if (gi == 0) begin : gFirst
        assign stBypass = channelDivControl[`BIT_BYPASS1];
        assign stStart = channelDivControl[`BIT_START_HIGH1];
        assign stLow = stage1Counts[`FLD_LOW_HI:`FLD_LOW_LO];
        assign stHigh = stage1Counts[`FLD_HIGH_HI:`FLD_HIGH_LO];
        assign stPhase = stagePhaseOffsets[`FLD_PHASE1_HI:`FLD_PHASE1_LO];
      end else begin : gSecond
        assign stBypass = channelDivControl[`BIT_BYPASS2];
        assign stStart = channelDivControl[`BIT_START_HIGH2];
        assign stLow = stage2Counts[`FLD_LOW_HI:`FLD_LOW_LO];
        assign stHigh = stage2Counts[`FLD_HIGH_HI:`FLD_HIGH_LO];
        assign stPhase = stagePhaseOffsets[`FLD_PHASE2_HI:`FLD_PHASE2_LO];
      end

      // Each stage steps on the previous output's ticks, so ratios multiply
      div_stage uStage (
        .mclk(mclk),
        .rst(rst),
        .inTick(chainTick[gi]),
        .inLevel(chainLevel[gi]),
        .bypass(stBypass),
        .alignHold(alignHold),
        .startHigh(stStart),
        .lowCount(stLow),
        .highCount(stHigh),
        .phase(stPhase),
        .outTick(chainTick[gi + 1]),
        .outLevel(chainLevel[gi + 1])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Duty-cycle correction

  // Measures the divided period in mclk cycles between rising edges and
  // regenerates a level that is high for the first half of it. The trade:
  // one period of latency after any ratio change before the duty settles.
  reg [`PERIOD_W-1:0] periodCnt;
  reg [`PERIOD_W-1:0] lastPeriod;
  reg corrLevel;

  wire dutyCorrOn;
  wire [`PERIOD_W-1:0] halfPeriod;
  wire periodFull;

  assign dutyCorrOn = ~dutyCorrControl[`BIT_DUTY_CORR_DISABLE];
  assign halfPeriod = {1'b0, lastPeriod[`PERIOD_W-1:1]};
  assign periodFull = &periodCnt;

  // Period counter restarts on every divided rising edge
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      periodCnt <= {`PERIOD_W{1'b0}};
      lastPeriod <= {`PERIOD_W{1'b0}};
      corrLevel <= 1'b0;
    end else if (alignHold || chainTick[2] == 1'b0 && periodFull) begin
      // Alignment or a stalled chain invalidates the measurement
      periodCnt <= alignHold ? {`PERIOD_W{1'b0}} : periodCnt;
      lastPeriod <= {`PERIOD_W{1'b0}};
      corrLevel <= chainLevel[2];
    end else if (chainTick[2]) begin
      lastPeriod <= periodCnt + {{(`PERIOD_W-1){1'b0}}, 1'b1};
      periodCnt <= {`PERIOD_W{1'b0}};
      corrLevel <= 1'b1;
    end else begin
      periodCnt <= periodCnt + {{(`PERIOD_W-1){1'b0}}, 1'b1};
      if (lastPeriod == {`PERIOD_W{1'b0}}) begin
        corrLevel <= chainLevel[2];
      end else begin
        // The tick cycle already drove one high cycle, so stop one count early
        corrLevel <= (periodCnt + {{(`PERIOD_W-1){1'b0}}, 1'b1} < halfPeriod) ? 1'b1 : 1'b0;
      end
    end
  end

  // In bypass the second stage carries the first stage's output unchanged; correct
  // only when that stage actually divides
  wire corrApplies;

  assign corrApplies = dutyCorrOn & ~channelDivControl[`BIT_BYPASS2];

  ////////////////////////////////////////////////////////////////////////
  // Channel output

  wire forceHigh;

  // Force-high needs the ignore-alignment bit set as well
  assign forceHigh = ignoreAlign & channelDivControl[`BIT_FORCE_HIGH];

  // Output register; the force wins over the divided clock
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      chanOut <= 1'b0;
    end else if (forceHigh) begin
      chanOut <= 1'b1;
    end else if (corrApplies) begin
      chanOut <= corrLevel;
    end else begin
      chanOut <= chainLevel[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status view

  // Live state for software: output, stage levels, alignment hold
  assign statusByte = {4'h0, alignHold, chainLevel[2], chainLevel[1], chanOut};

endmodule

`default_nettype wire

// ---- bench/chan_div_sva.sv ----
// Checker for the divider pair: APB answer timing and output levels.
// Bound to the top module; sees its ports only.
`default_nettype none
module chan_div_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic alignIn,
  input wire logic chanOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [7:0] ctl;
  logic duty_correction_disable;
  logic setup;
  logic inMap;
  ////////////////////////////////
  // Shadow of the mode bits, so level checks know what was programmed
  assign setup = psel && !penable;
  assign inMap = paddr >= 12'h678 && paddr <= 12'h68c && paddr[1:0] == 2'h0;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl <= 8'h00;
      duty_correction_disable <= 1'b0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == 12'h684) ctl <= pwdata[7:0];
      if (paddr == 12'h688) duty_correction_disable <= pwdata[0];
    end
  end
  ////////////////////////////////
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than a cycle");
  a_setup_answer: assert property (setup |=> pready)
    else $error("no answer after setup");
  a_ready_cause: assert property (!setup |=> !pready)
    else $error("ready without setup");
  a_err_unmapped: assert property (setup && !inMap |=> pslverr)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (setup && inMap && !(pwrite && paddr == 12'h68c) |=> !pslverr)
    else $error("mapped access refused");
  a_err_status: assert property (setup && pwrite && paddr == 12'h68c |=> pslverr)
    else $error("status write not refused");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_force_high: assert property ((ctl[3] && ctl[2] && duty_correction_disable)[*6] |-> chanOut)
    else $error("forced output not high");
  a_align_level: assert property ((alignIn && !ctl[3] && !ctl[4] && duty_correction_disable)[*6]
    |-> chanOut == (ctl[5] ? ctl[0] : ctl[1])) else $error("held level wrong");
  c_write: cover property (setup && pwrite ##1 pready);
  c_refused: cover property (pready && pslverr);
  c_aligned: cover property ((alignIn && !ctl[3])[*8]);
endmodule
bind channel_clock_divider_pair chan_div_sva i_chan_div_sva (.mclk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .alignIn, .chanOut);
`default_nettype wire

// ---- bench/chan_out_monitor.sv ----
// Downstream clock consumer: measures high and low runs of the output.
// Assumes the output is a level registered on mclk.
`default_nettype none
module chan_out_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic chanOut,
  output logic [15:0] lastHigh,
  output logic [15:0] lastLow,
  output logic [15:0] edges
);
  logic [15:0] run;
  logic prev;
  // A change closes the run of the old level; lengths in mclk cycles
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      run <= 16'h1;
      prev <= 1'b0;
      lastHigh <= 16'h0;
      lastLow <= 16'h0;
      edges <= 16'h0;
    end else if (chanOut != prev) begin
      if (prev) lastHigh <= run;
      else lastLow <= run;
      run <= 16'h1;
      edges <= edges + 16'h1;
      prev <= chanOut;
    end else begin
      run <= run + 16'h1;
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Bench for the divider pair: APB master, scenario tasks, verdict.
// Assumes the design, checker and output monitor are compiled first.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_C1 = 12'h678, A_PH = 12'h67c, A_C2 = 12'h680;
  localparam logic [11:0] A_CTL = 12'h684, A_DCC = 12'h688, A_ST = 12'h68c;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic alignIn = 1'b0, ph2 = 1'b0, pready, pslverr, chanOut;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] hi, lo, ed;
  int err_total = 0, num_checks = 0;
  ////////////////////////////////
  // Parity bit keeps alignment releases on one input clock phase
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) ph2 <= ~ph2;
  channel_clock_divider_pair i_channel_clock_divider_pair (.mclk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .alignIn, .chanOut);
  chan_out_monitor i_chan_out_monitor (.mclk, .rst, .chanOut, .lastHigh(hi), .lastLow(lo),
    .edges(ed));
  ////////////////////////////////
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic hung(input string m);
    err_total++;
    $display("unexpected at %0t: %s timed out", $time, m);
    close_out();
  endtask
  task automatic check(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) hung("apb");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  // Program a ratio, let it settle, compare the measured runs
  task automatic meas(input logic [7:0] c1, c2, ctl, input logic dcc);
    logic [15:0] h, l, p, e0;
    int n;
    h = ctl[4] ? 16'h1 : 16'h2 * ({12'h0, c1[3:0]} + 16'h1);
    l = ctl[4] ? 16'h1 : 16'h2 * ({12'h0, c1[7:4]} + 16'h1);
    p = h + l;
    if (!ctl[5]) begin
      h = p * ({12'h0, c2[3:0]} + 16'h1);
      l = p * ({12'h0, c2[7:4]} + 16'h1);
      p = h + l;
      if (dcc) h = p / 16'h2;
      if (dcc) l = p - h;
    end
    wr(A_DCC, {7'h0, !dcc});
    wr(A_C1, c1);
    wr(A_C2, c2);
    wr(A_CTL, ctl);
    e0 = ed;
    n = 0;
    while (ed - e0 < 16'h8 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000) hung("edges");
    check({16'h0, hi}, {16'h0, h}, "high run");
    check({16'h0, lo}, {16'h0, l}, "low run");
  endtask
  // Hold alignment, check the held level (or, when ignored, that edges go on), time the first change after release
  task automatic align_run(input logic [7:0] ctl, ph, output int dly);
    logic lvl;
    logic [15:0] e0;
    lvl = ctl[5] ? ctl[0] : ctl[1];
    wr(A_CTL, ctl);
    wr(A_PH, ph);
    @(posedge mclk);
    alignIn <= 1'b1;
    e0 = ed;
    repeat (40) @(posedge mclk);
    if (ctl[3]) check({31'h0, ed != e0}, 32'h1, "ignored align");
    else check({31'h0, chanOut}, {31'h0, lvl}, "held level");
    while (ph2) @(posedge mclk);
    alignIn <= 1'b0;
    dly = 0;
    while (chanOut === lvl && dly < 500) begin
      @(posedge mclk);
      dly++;
    end
    if (dly >= 500) hung("release");
  endtask
  ////////////////////////////////
  task automatic t_regs;
    logic [11:0] ad[5] = '{A_C1, A_PH, A_C2, A_CTL, A_DCC};
    logic [7:0] v[5] = '{8'ha5, 8'h3c, 8'h5a, 8'h3f, 8'h01};
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ad[i], 8'h00, r, e);
      check(r, 32'h0, "reset value");
      wr(ad[i], v[i]);
      apb(1'b0, ad[i], 8'h00, r, e);
      check(r, {24'h0, v[i]}, "readback");
      wr(ad[i], 8'h00);
    end
    apb(1'b0, 12'h690, 8'h00, r, e);
    check({31'h0, e}, 32'h1, "unmapped");
    apb(1'b1, A_ST, 8'h01, r, e);
    check({31'h0, e}, 32'h1, "status write");
  endtask
  task automatic t_ratio;
    meas(8'h00, 8'h00, 8'h00, 1'b0);
    meas(8'h21, 8'h10, 8'h00, 1'b0);
    meas(8'h0f, 8'h00, 8'h00, 1'b0);
    meas(8'h00, 8'h0f, 8'h00, 1'b0);
  endtask
  task automatic t_bypass;
    meas(8'h0f, 8'h00, 8'h20, 1'b0);
    meas(8'h00, 8'h21, 8'h10, 1'b0);
    meas(8'h00, 8'h00, 8'h30, 1'b0);
  endtask
  task automatic t_dcc;
    meas(8'h00, 8'h10, 8'h00, 1'b1);
    meas(8'h00, 8'h10, 8'h00, 1'b0);
  endtask
  task automatic t_force;
    logic [15:0] e0;
    wr(A_CTL, 8'h0c);
    repeat (8) @(posedge mclk);
    e0 = ed;
    repeat (40) @(posedge mclk);
    check({31'h0, chanOut}, 32'h1, "forced level");
    check({16'h0, ed}, {16'h0, e0}, "forced edges");
    meas(8'h00, 8'h00, 8'h04, 1'b0);
  endtask
  task automatic t_align;
    int d0, d1;
    align_run(8'h20, 8'h00, d0);
    align_run(8'h20, 8'h03, d1);
    check(d1 - d0, 32'h6, "stage one offset");
    align_run(8'h10, 8'h00, d0);
    align_run(8'h10, 8'h30, d1);
    check(d1 - d0, 32'h6, "stage two offset");
    align_run(8'h21, 8'h00, d0);
    align_run(8'h02, 8'h00, d0);
    align_run(8'h08, 8'h00, d0);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_ratio();
    t_bypass();
    t_dcc();
    t_force();
    t_align();
    close_out();
  end
endmodule
`default_nettype wire
